// file: hdl/nfcsm_pkg.sv
// Package of constants and state types for the NOR flash command sequencer host
package nfcsm_pkg;
	// Flash bus, cycle counter and command step widths
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int CNT_W = 8;
	localparam int STEP_W = 3;

	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_CFG = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;

	// Operation codes written to the command register
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_PROG = 3'h2;
	localparam logic [2:0] OP_AUTOSEL = 3'h3;
	localparam logic [2:0] OP_RESET = 3'h4;
	localparam logic [2:0] OP_BYP_ENTER = 3'h5;
	localparam logic [2:0] OP_BYP_PROG = 3'h6;
	localparam logic [2:0] OP_BYP_EXIT = 3'h7;

	// Command data values of the bypass sequences
	localparam logic [7:0] CMD_BYP_ENTER = 8'h20;
	localparam logic [7:0] CMD_BYP_PROG = 8'hA0;
	localparam logic [7:0] CMD_BYP_RST1 = 8'h90;
	localparam logic [7:0] CMD_BYP_RST2 = 8'h00;

	// Configuration and status bit positions
	localparam int CFG_BYTE = 0;
	localparam int CFG_HWRST = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_READY = 1;
	localparam int ST_BYPASS = 2;
	localparam int ST_AUTOSEL = 3;
	localparam int ST_TIMEOUT = 4;
	localparam int ST_REFUSED = 5;

	// Status flag positions inside flash read data
	localparam int TOGGLE_BIT = 6;
	localparam int EXCEED_BIT = 5;

	// Bus timing, figures in ns and derived cycle counts
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_SETUP_NS = 10;
	localparam int T_WE_PULSE_NS = 40;
	localparam int T_HOLD_NS = 10;
	localparam int T_ACCESS_NS = 80;
	localparam int SYNC_CYC = 2;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC;

	typedef enum logic [4:0] {
		E_IDLE = 5'b00001,
		E_SETUP = 5'b00010,
		E_PULSE = 5'b00100,
		E_HOLD = 5'b01000,
		E_READ = 5'b10000
	} nfcsm_eng_state_type;

	typedef enum logic [4:0] {
		M_IDLE = 5'b00001,
		M_SEQ = 5'b00010,
		M_POLL = 5'b00100,
		M_RECOVER = 5'b01000,
		M_READ = 5'b10000
	} nfcsm_main_state_type;
endpackage : nfcsm_pkg

// file: hdl/nfcsm_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, timed in mclk cycles
`timescale 1ns/1ps
module nfcsm_bus_cycle (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic start, // Start one cycle
	input wire logic is_write, // Cycle direction
	input wire logic [nfcsm_pkg::ADDR_W-1:0] addr_in, // Cycle address
	input wire logic [nfcsm_pkg::DATA_W-1:0] data_in, // Write data
	output logic done, // Cycle finished pulse
	output logic [nfcsm_pkg::DATA_W-1:0] rdata, // Captured read data
	output logic [nfcsm_pkg::ADDR_W-1:0] flash_addr, // Address pins
	output logic [nfcsm_pkg::DATA_W-1:0] flash_dq_o, // Data pins out
	output logic flash_dq_oe, // Data pins driven
	input wire logic [nfcsm_pkg::DATA_W-1:0] flash_dq_i, // Data pins in
	output logic flash_ce_n, // Chip select
	output logic flash_oe_n, // Output enable
	output logic flash_we_n // Write strobe
);
	nfcsm_pkg::nfcsm_eng_state_type state_reg;
	logic [nfcsm_pkg::CNT_W-1:0] cnt_reg;
	logic [nfcsm_pkg::DATA_W-1:0] dq_s1_reg;
	logic [nfcsm_pkg::DATA_W-1:0] dq_s2_reg;
	wire cnt_zero = (cnt_reg == '0);

	// Read data crosses from the pins through two flops
	always_ff @(posedge mclk) begin
		dq_s1_reg <= flash_dq_i;
		dq_s2_reg <= dq_s1_reg;
	end

	// Strobe sequencer; we_n only falls with ce_n low and oe_n high
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= nfcsm_pkg::E_IDLE;
			cnt_reg <= '0;
			done <= 1'b0;
			rdata <= '0;
			flash_addr <= '0;
			flash_dq_o <= '0;
			flash_dq_oe <= 1'b0;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1; // Strobe high from power-up
		end else begin
			done <= 1'b0;
			if (!cnt_zero)
				cnt_reg <= cnt_reg - 1'b1;
			case (state_reg)
				nfcsm_pkg::E_IDLE: begin
					if (start) begin
						flash_addr <= addr_in; // Address driven at the same edge that chip select falls
						flash_dq_o <= data_in;
						flash_dq_oe <= is_write;
						flash_ce_n <= 1'b0;
						flash_oe_n <= is_write; // Output enable high for writes
						cnt_reg <= is_write ? nfcsm_pkg::CNT_W'(nfcsm_pkg::SETUP_CYC - 1)
							: nfcsm_pkg::CNT_W'(nfcsm_pkg::READ_CYC - 1);
						state_reg <= is_write ? nfcsm_pkg::E_SETUP : nfcsm_pkg::E_READ;
					end
				end
				nfcsm_pkg::E_SETUP: begin
					if (cnt_zero) begin
						flash_we_n <= 1'b0; // Write pulse begins
						cnt_reg <= nfcsm_pkg::CNT_W'(nfcsm_pkg::PULSE_CYC - 1);
						state_reg <= nfcsm_pkg::E_PULSE;
					end
				end
				nfcsm_pkg::E_PULSE: begin
					if (cnt_zero) begin
						flash_we_n <= 1'b1; // Data still driven at this rising edge
						cnt_reg <= nfcsm_pkg::CNT_W'(nfcsm_pkg::HOLD_CYC - 1);
						state_reg <= nfcsm_pkg::E_HOLD;
					end
				end
				nfcsm_pkg::E_HOLD: begin
					if (cnt_zero) begin
						flash_ce_n <= 1'b1;
						flash_dq_oe <= 1'b0;
						done <= 1'b1;
						state_reg <= nfcsm_pkg::E_IDLE;
					end
				end
				nfcsm_pkg::E_READ: begin
					if (cnt_zero) begin
						rdata <= dq_s2_reg;
						flash_ce_n <= 1'b1;
						flash_oe_n <= 1'b1;
						done <= 1'b1;
						state_reg <= nfcsm_pkg::E_IDLE;
					end
				end
				default: state_reg <= nfcsm_pkg::E_IDLE;
			endcase
		end
	end

	AST_WRITE_QUALIFIED: assert property (@(posedge mclk) disable iff (rst)
		!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
		else $error("write strobe low without chip select or with output enable");
	AST_DATA_AT_RISE: assert property (@(posedge mclk) disable iff (rst)
		$rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n && $stable(flash_dq_o))
		else $error("data not held at write strobe rising edge");
	AST_ADDR_STABLE: assert property (@(posedge mclk) disable iff (rst)
		!flash_we_n |-> $stable(flash_addr))
		else $error("address moved during write pulse");
	AST_PULSE_WIDTH: assert property (@(posedge mclk) disable iff (rst)
		$fell(flash_we_n) |-> (!flash_we_n) [*4] ##1 flash_we_n)
		else $error("write pulse width wrong");
endmodule : nfcsm_bus_cycle

// file: hdl/nfcsm_host.sv
// Host controller that drives a parallel NOR flash command interface from Wishbone registers
// Function
// - Write only with chip select and strobe low, output enable high.
// - On exceeded-time flag host writes reset; device returns to read-array.
// - Reset cancels partial autoselect; reset needed to leave autoselect mode.
// - Two unlocks plus autoselect command; then reads at any address.
// - Program is two unlocks, set-up, then address and data.
// - Bypass entered by two unlocks then command 20h.
// - Bypass program is A0h then address and data; other commands refused.
// - Bypass left by writing 90h then 00h, addresses ignored.
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module nfcsm_host #(
	parameter logic [nfcsm_pkg::ADDR_W-1:0] UNLOCK1_ADDR = 21'h00001, // Arbitrary default
	parameter logic [7:0] UNLOCK1_DATA = 8'h5A, // Arbitrary default
	parameter logic [nfcsm_pkg::ADDR_W-1:0] UNLOCK2_ADDR = 21'h00002, // Arbitrary default
	parameter logic [7:0] UNLOCK2_DATA = 8'hA5, // Arbitrary default
	parameter logic [7:0] PROG_SETUP_CMD = 8'hA0, // Program set-up command
	parameter logic [7:0] AUTOSEL_CMD = 8'h90, // Autoselect command
	parameter logic [7:0] RESET_CMD = 8'hF0 // Reset command
) (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	input wire logic wb_we_i, // Wishbone write
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_cyc_i, // Wishbone cycle
	output logic wb_ack_o, // Wishbone acknowledge
	output logic [nfcsm_pkg::ADDR_W-1:0] flash_addr, // Flash address pins
	output logic [nfcsm_pkg::DATA_W-1:0] flash_dq_o, // Flash data out
	output logic flash_dq_oe, // Flash data driven
	input wire logic [nfcsm_pkg::DATA_W-1:0] flash_dq_i, // Flash data in
	output logic flash_ce_n, // Flash chip select
	output logic flash_oe_n, // Flash output enable
	output logic flash_we_n, // Flash write strobe
	output logic flash_byte_n, // Width select, low for byte
	output logic flash_reset_n, // Flash hardware reset
	input wire logic flash_ready_busy_n, // Flash ready/busy pin
	input wire logic supply_ok // Supply above lockout threshold
);
	nfcsm_pkg::nfcsm_main_state_type state_reg;
	logic [2:0] op_reg;
	logic [nfcsm_pkg::STEP_W-1:0] step_reg;
	logic [nfcsm_pkg::ADDR_W-1:0] addr_reg;
	logic [nfcsm_pkg::DATA_W-1:0] wdata_reg;
	logic [nfcsm_pkg::DATA_W-1:0] rdata_reg;
	logic [nfcsm_pkg::DATA_W-1:0] prev_reg;
	logic [1:0] cfg_reg;
	logic bypass_reg, autosel_reg, timeout_reg, refused_reg, first_reg, strike_reg;
	logic eng_start_reg, eng_write_reg;
	logic [nfcsm_pkg::ADDR_W-1:0] eng_addr_reg;
	logic [nfcsm_pkg::DATA_W-1:0] eng_data_reg;
	logic [1:0] rb_sync_reg, sup_sync_reg;
	logic eng_done;
	logic [nfcsm_pkg::DATA_W-1:0] eng_rdata;

	// Command cycle table: {address, data} of each write step
	function automatic logic [nfcsm_pkg::ADDR_W+nfcsm_pkg::DATA_W-1:0] step_word(
		input logic [2:0] op, input logic [nfcsm_pkg::STEP_W-1:0] st,
		input logic [nfcsm_pkg::ADDR_W-1:0] a, input logic [nfcsm_pkg::DATA_W-1:0] d);
		logic [7:0] cmd;
		cmd = RESET_CMD;
		step_word = '0;
		if (op == nfcsm_pkg::OP_BYP_PROG || op == nfcsm_pkg::OP_BYP_EXIT) begin
			cmd = (op == nfcsm_pkg::OP_BYP_PROG) ? nfcsm_pkg::CMD_BYP_PROG : nfcsm_pkg::CMD_BYP_RST1;
			if (op == nfcsm_pkg::OP_BYP_EXIT && st != '0)
				cmd = nfcsm_pkg::CMD_BYP_RST2;
			step_word = (op == nfcsm_pkg::OP_BYP_PROG && st != '0) ? {a, d} : {a, 8'h00, cmd};
		end else if (op == nfcsm_pkg::OP_RESET)
			step_word = {a, 8'h00, RESET_CMD}; // Any address will do
		else if (st == 3'h0)
			step_word = {UNLOCK1_ADDR, 8'h00, UNLOCK1_DATA};
		else if (st == 3'h1)
			step_word = {UNLOCK2_ADDR, 8'h00, UNLOCK2_DATA};
		else if (st == 3'h3)
			step_word = {a, d}; // Target cycle starts the embedded program
		else begin
			cmd = (op == nfcsm_pkg::OP_PROG) ? PROG_SETUP_CMD
				: (op == nfcsm_pkg::OP_AUTOSEL) ? AUTOSEL_CMD : nfcsm_pkg::CMD_BYP_ENTER;
			step_word = {UNLOCK1_ADDR, 8'h00, cmd};
		end
	endfunction : step_word

	// Index of the last write step of an operation
	function automatic logic [nfcsm_pkg::STEP_W-1:0] last_step(input logic [2:0] op);
		case (op)
			nfcsm_pkg::OP_PROG: last_step = 3'h3;
			nfcsm_pkg::OP_AUTOSEL, nfcsm_pkg::OP_BYP_ENTER: last_step = 3'h2;
			nfcsm_pkg::OP_BYP_PROG, nfcsm_pkg::OP_BYP_EXIT: last_step = 3'h1;
			default: last_step = 3'h0;
		endcase
	endfunction : last_step

	// Operations legal in the current mode; keeps the device off its abort path
	function automatic logic op_legal(input logic [2:0] op, input logic byp, input logic asel);
		if (byp)
			op_legal = op == nfcsm_pkg::OP_READ || op == nfcsm_pkg::OP_BYP_PROG
				|| op == nfcsm_pkg::OP_BYP_EXIT;
		else if (asel)
			op_legal = op == nfcsm_pkg::OP_READ || op == nfcsm_pkg::OP_RESET;
		else
			op_legal = op != nfcsm_pkg::OP_NONE && op != nfcsm_pkg::OP_BYP_PROG
				&& op != nfcsm_pkg::OP_BYP_EXIT;
	endfunction : op_legal

	// Byte-lane merge for register writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			lane_merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction : lane_merge

	// Bus decode; ack is registered, and a write lands only at the edge where ack is seen high
	wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	wire idle = (state_reg == nfcsm_pkg::M_IDLE);
	wire [2:0] new_op = wb_dat_i[2:0];
	wire cmd_wr = wb_wr && wb_sel_i[0] && (wb_adr_i == nfcsm_pkg::REG_CMD) && (new_op != nfcsm_pkg::OP_NONE);
	wire sup_ok = sup_sync_reg[1];
	wire op_ok = idle && op_legal(new_op, bypass_reg, autosel_reg) && !cfg_reg[nfcsm_pkg::CFG_HWRST]
		&& (sup_ok || new_op == nfcsm_pkg::OP_READ); // No writes without supply
	wire accept = cmd_wr && op_ok;
	wire seq_last = (step_reg == last_step(op_reg));
	wire polls = (op_reg == nfcsm_pkg::OP_PROG) || (op_reg == nfcsm_pkg::OP_BYP_PROG);
	wire toggling = (prev_reg[nfcsm_pkg::TOGGLE_BIT] != eng_rdata[nfcsm_pkg::TOGGLE_BIT]);
	wire [31:0] st_word = {26'h0, refused_reg, timeout_reg, autosel_reg, bypass_reg, rb_sync_reg[1], !idle};
	wire [31:0] rd_word = (wb_adr_i == nfcsm_pkg::REG_CMD) ? {29'h0, op_reg}
		: (wb_adr_i == nfcsm_pkg::REG_ADDR) ? {11'h0, addr_reg}
		: (wb_adr_i == nfcsm_pkg::REG_WDATA) ? {16'h0, wdata_reg}
		: (wb_adr_i == nfcsm_pkg::REG_CFG) ? {30'h0, cfg_reg}
		: (wb_adr_i == nfcsm_pkg::REG_STATUS) ? st_word
		: (wb_adr_i == nfcsm_pkg::REG_RDATA) ? {16'h0, rdata_reg} : 32'h0;
	wire clr_hit = wb_wr && wb_sel_i[0] && (wb_adr_i == nfcsm_pkg::REG_STATUS);
	wire [nfcsm_pkg::ADDR_W+nfcsm_pkg::DATA_W-1:0] next_word = step_word(op_reg,
		nfcsm_pkg::STEP_W'(step_reg + 1'b1), addr_reg, wdata_reg);
	wire [nfcsm_pkg::ADDR_W+nfcsm_pkg::DATA_W-1:0] first_word = step_word(new_op, '0, addr_reg, wdata_reg);

	// Pin-level inputs through two flops
	always_ff @(posedge mclk) begin
		rb_sync_reg <= {rb_sync_reg[0], flash_ready_busy_n}; // Busy shown while program runs
		sup_sync_reg <= {sup_sync_reg[0], supply_ok};
	end

	// Wishbone slave registers; sticky flags take a set over a clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			addr_reg <= '0;
			wdata_reg <= '0;
			cfg_reg <= '0;
			refused_reg <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= wb_hit ? rd_word : 32'h0;
			if (wb_wr && wb_adr_i == nfcsm_pkg::REG_ADDR)
				addr_reg <= nfcsm_pkg::ADDR_W'(lane_merge({11'h0, addr_reg}, wb_dat_i, wb_sel_i));
			if (wb_wr && wb_adr_i == nfcsm_pkg::REG_WDATA)
				wdata_reg <= nfcsm_pkg::DATA_W'(lane_merge({16'h0, wdata_reg}, wb_dat_i, wb_sel_i));
			if (wb_wr && wb_sel_i[0] && wb_adr_i == nfcsm_pkg::REG_CFG)
				cfg_reg <= wb_dat_i[1:0];
			if (cmd_wr && !op_ok)
				refused_reg <= 1'b1;
			else if (clr_hit && wb_dat_i[nfcsm_pkg::ST_REFUSED])
				refused_reg <= 1'b0;
		end
	end

	// Command sequencer: write steps, then toggle polling for programs
	always_ff @(posedge mclk) begin
		if (rst || cfg_reg[nfcsm_pkg::CFG_HWRST]) begin // Hardware reset drops any program
			state_reg <= nfcsm_pkg::M_IDLE;
			op_reg <= nfcsm_pkg::OP_NONE;
			step_reg <= '0;
			bypass_reg <= 1'b0;
			autosel_reg <= 1'b0; // Device back in read-array
			first_reg <= 1'b0;
			strike_reg <= 1'b0;
			prev_reg <= '0;
			eng_start_reg <= 1'b0;
			eng_write_reg <= 1'b0;
			eng_addr_reg <= '0;
			eng_data_reg <= '0;
			if (rst) begin
				rdata_reg <= '0;
				timeout_reg <= 1'b0;
			end
		end else begin
			eng_start_reg <= 1'b0;
			if (clr_hit && wb_dat_i[nfcsm_pkg::ST_TIMEOUT])
				timeout_reg <= 1'b0;
			case (state_reg)
				nfcsm_pkg::M_IDLE: begin
					if (accept) begin
						op_reg <= new_op;
						step_reg <= '0;
						eng_start_reg <= 1'b1;
						eng_write_reg <= new_op != nfcsm_pkg::OP_READ;
						eng_addr_reg <= (new_op == nfcsm_pkg::OP_READ) ? addr_reg : first_word[nfcsm_pkg::DATA_W +: nfcsm_pkg::ADDR_W];
						eng_data_reg <= first_word[nfcsm_pkg::DATA_W-1:0];
						state_reg <= (new_op == nfcsm_pkg::OP_READ) ? nfcsm_pkg::M_READ : nfcsm_pkg::M_SEQ;
					end
				end
				nfcsm_pkg::M_SEQ: begin
					if (eng_done && !seq_last) begin
						step_reg <= step_reg + 1'b1;
						eng_start_reg <= 1'b1;
						{eng_addr_reg, eng_data_reg} <= next_word;
					end else if (eng_done) begin
						eng_start_reg <= polls;
						eng_write_reg <= 1'b0;
						eng_addr_reg <= addr_reg; // Polling reads the target word
						first_reg <= 1'b1;
						strike_reg <= 1'b0;
						state_reg <= polls ? nfcsm_pkg::M_POLL : nfcsm_pkg::M_IDLE;
						if (op_reg == nfcsm_pkg::OP_AUTOSEL)
							autosel_reg <= 1'b1;
						if (op_reg == nfcsm_pkg::OP_RESET)
							autosel_reg <= 1'b0;
						if (op_reg == nfcsm_pkg::OP_BYP_ENTER || op_reg == nfcsm_pkg::OP_BYP_EXIT)
							bypass_reg <= op_reg == nfcsm_pkg::OP_BYP_ENTER;
					end
				end
				nfcsm_pkg::M_POLL: begin
					if (eng_done) begin
						prev_reg <= eng_rdata;
						first_reg <= 1'b0;
						if (!first_reg && !toggling) begin
							rdata_reg <= eng_rdata; // Toggle stopped, device in read-array
							state_reg <= nfcsm_pkg::M_IDLE;
						end else if (!first_reg && strike_reg) begin
							eng_start_reg <= 1'b1;
							eng_write_reg <= 1'b1;
							eng_data_reg <= {8'h00, RESET_CMD}; // Exceeded time: reset to read-array
							state_reg <= nfcsm_pkg::M_RECOVER;
						end else begin
							strike_reg <= !first_reg && eng_rdata[nfcsm_pkg::EXCEED_BIT];
							eng_start_reg <= 1'b1;
						end
					end
				end
				nfcsm_pkg::M_RECOVER: begin
					if (eng_done) begin
						timeout_reg <= 1'b1;
						state_reg <= nfcsm_pkg::M_IDLE;
					end
				end
				nfcsm_pkg::M_READ: begin
					if (eng_done) begin
						rdata_reg <= eng_rdata; // Autoselect codes read like array data
						state_reg <= nfcsm_pkg::M_IDLE;
					end
				end
				default: state_reg <= nfcsm_pkg::M_IDLE;
			endcase
		end
	end

	assign flash_byte_n = !cfg_reg[nfcsm_pkg::CFG_BYTE]; // Width select for program
	assign flash_reset_n = !cfg_reg[nfcsm_pkg::CFG_HWRST];

	nfcsm_bus_cycle u_cycle (
		.mclk(mclk),
		.rst(rst || cfg_reg[nfcsm_pkg::CFG_HWRST]),
		.start(eng_start_reg),
		.is_write(eng_write_reg),
		.addr_in(eng_addr_reg),
		.data_in(eng_data_reg),
		.done(eng_done),
		.rdata(eng_rdata),
		.flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_i(flash_dq_i),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n)
	);

	sequence s_seq_done(logic [2:0] op);
		state_reg == nfcsm_pkg::M_SEQ && eng_done && seq_last && op_reg == op;
	endsequence
	AST_RESET_IDLE: assert property (@(posedge mclk) rst |=> idle && !bypass_reg && !autosel_reg)
		else $error("sequencer not idle after reset");
	AST_BYPASS_REFUSE: assert property (@(posedge mclk) disable iff (rst)
		cmd_wr && bypass_reg && new_op == nfcsm_pkg::OP_PROG |=> !eng_start_reg && refused_reg)
		else $error("plain program accepted in bypass mode");
	AST_BYPASS_EXIT: assert property (@(posedge mclk) disable iff (rst)
		s_seq_done(nfcsm_pkg::OP_BYP_EXIT) |=> !bypass_reg && idle)
		else $error("bypass mode kept after exit sequence");
	AST_AUTOSEL_SET: assert property (@(posedge mclk) disable iff (rst)
		s_seq_done(nfcsm_pkg::OP_AUTOSEL) |=> autosel_reg ##1 autosel_reg)
		else $error("autoselect mode not entered");
	AST_TIMEOUT_RESET: assert property (@(posedge mclk) disable iff (rst)
		$rose(state_reg == nfcsm_pkg::M_RECOVER) |-> eng_start_reg && eng_write_reg
		&& eng_data_reg[7:0] == RESET_CMD ##[1:40] timeout_reg)
		else $error("exceeded time not followed by reset command");
	AST_NO_WRITE_UNSUPPLIED: assert property (@(posedge mclk) disable iff (rst)
		cmd_wr && !sup_ok && new_op != nfcsm_pkg::OP_READ |=> !eng_start_reg)
		else $error("write started without supply");
endmodule : nfcsm_host

// file: bench/nfcsm_flash_model.sv
// Behavioural flash device answering the host's command and read cycles
`timescale 1ns/1ps
module nfcsm_flash_model #(
	parameter logic [20:0] U1A = 21'h00001, // Unlock address one
	parameter logic [7:0] U1D = 8'h5A, // Unlock data one
	parameter logic [20:0] U2A = 21'h00002, // Unlock address two
	parameter logic [7:0] U2D = 8'hA5, // Unlock data two
	parameter logic [15:0] MAKER = 16'h00C3, // Arbitrary value
	parameter logic [15:0] DEV = 16'h1234 // Arbitrary value
) (
	input wire logic [20:0] addr, // Address pins
	input wire logic [15:0] dq_in, // Data from host
	output logic [15:0] dq_out, // Data to host
	input wire logic ce_n, // Chip select
	input wire logic oe_n, // Output enable
	input wire logic we_n, // Write strobe
	input wire logic reset_n, // Hardware reset
	input wire logic vcc_ok, // Supply above lockout threshold
	output logic rb_n // Ready/busy
);
	logic [15:0] mem [16];
	logic [15:0] rd;
	logic [15:0] last = 16'h0000;
	logic [7:0] d;
	int step = 0; // Power-up in read-array
	logic asel = 1'b0;
	logic byp = 1'b0;
	logic tog = 1'b0;
	logic stuck = 1'b0;
	initial rb_n = 1'b1;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	// Command decoder; writes qualified by strobes, supply and idle
	// A halted program takes only the reset command
	always @(posedge we_n) if (!ce_n && oe_n && vcc_ok && reset_n && (rb_n || (stuck && dq_in[7:0] == 8'hF0))) begin
		d = dq_in[7:0];
		if (d == 8'hF0 && !byp && step != 4) begin
			step = 0; // Address ignored
			asel = 1'b0;
			stuck = 1'b0;
			rb_n <= 1'b1;
		end else if (step == 4) begin
			stuck = |(dq_in & ~mem[addr[3:0]]); // Raising a bit halts with exceeded time
			mem[addr[3:0]] = mem[addr[3:0]] & dq_in; // Only clears bits
			rb_n <= 1'b0; // Busy for the whole algorithm
			if (!stuck)
				rb_n <= #500 1'b1;
			step = 0;
		end else if (byp) begin
			step = (d == 8'hA0) ? 4 : (d == 8'h90) ? 6 : 0; // Only bypass commands
			if (step == 0 && d == 8'h00) byp = 1'b0; // Exit returns to read-array
		end else if (asel) step = 0; // No erase state, reset leaves autoselect to read-array
		else if (step == 0) step = (addr == U1A && d == U1D) ? 1 : 0; // Bad cycle aborts
		else if (step == 1) step = (addr == U2A && d == U2D) ? 2 : 0;
		else begin
			step = (addr == U1A && d == 8'hA0) ? 4 : 0;
			asel = (addr == U1A && d == 8'h90);
			byp = (addr == U1A && d == 8'h20);
		end
	end
	// Lockout or hardware reset clears state and aborts programming
	always @(negedge reset_n or negedge vcc_ok) begin
		step = 0;
		asel = 1'b0;
		byp = 1'b0;
		stuck = 1'b0;
		rb_n <= 1'b1;
	end
	// Status toggles per read while busy
	always @(negedge oe_n) if (!rb_n) tog = !tog;
	always @(posedge oe_n) last = rd;
	// Codes in autoselect, sectors all unprotected
	assign rd = !rb_n ? {9'h000, tog, stuck, 5'h00}
		: asel ? (addr[7:0] == 8'h00 ? MAKER : addr[7:0] == 8'h01 ? DEV : 16'h0000)
		: mem[addr[3:0]];
	// Released bus shows inverse of last value
	assign dq_out = (!ce_n && !oe_n) ? rd : ~last;
endmodule : nfcsm_flash_model

// file: bench/tb_top.sv
// Self-checking bench of the flash host against the device model
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_we_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_ack_o;
	logic [20:0] fa;
	logic [15:0] fdo, fdi;
	logic fdoe, fce, foe, fwe, fbyte, frst, frb;
	logic supply_ok = 1'b1;
	logic [31:0] rd;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	always #5 mclk = ~mclk;
	nfcsm_host nfcsm_host_i (.mclk(mclk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_we_i(wb_we_i), .wb_sel_i(4'hF), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
		.flash_addr(fa), .flash_dq_o(fdo), .flash_dq_oe(fdoe), .flash_dq_i(fdi), .flash_ce_n(fce), .flash_oe_n(foe),
		.flash_we_n(fwe), .flash_byte_n(fbyte), .flash_reset_n(frst), .flash_ready_busy_n(frb), .supply_ok(supply_ok));
	nfcsm_flash_model nfcsm_flash_model_i (.addr(fa), .dq_in(fdo), .dq_out(fdi), .ce_n(fce), .oe_n(foe), .we_n(fwe),
		.reset_n(frst), .vcc_ok(supply_ok), .rb_n(frb));
	// Classic single Wishbone cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_we_i <= w;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	// Issue an operation and wait for busy to clear
	task op(input logic [2:0] o);
		wb(1'b1, nfcsm_pkg::REG_CMD, {29'h0, o});
		do wb(1'b0, nfcsm_pkg::REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
	endtask : op
	task rdat(input logic [20:0] a);
		wb(1'b1, nfcsm_pkg::REG_ADDR, {11'h0, a});
		op(nfcsm_pkg::OP_READ);
		wb(1'b0, nfcsm_pkg::REG_RDATA, 32'h0);
	endtask : rdat
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task prog(input logic [2:0] o, input logic [20:0] a, input logic [15:0] d);
		wb(1'b1, nfcsm_pkg::REG_ADDR, {11'h0, a});
		wb(1'b1, nfcsm_pkg::REG_WDATA, {16'h0, d});
		op(o);
	endtask : prog
	task close_out;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	// Timeout guard counts as a mismatch
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 60000) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		prog(nfcsm_pkg::OP_PROG, 21'h3, 16'h1234);
		rdat(21'h3);
		chk(rd, 32'h1234);
		prog(nfcsm_pkg::OP_PROG, 21'h3, 16'hFF00);
		chk(rd & 32'h10, 32'h10);
		rdat(21'h3);
		chk(rd, 32'h1200);
		op(nfcsm_pkg::OP_BYP_PROG);
		chk(rd & 32'h20, 32'h20);
		wb(1'b1, nfcsm_pkg::REG_STATUS, 32'h30);
		op(nfcsm_pkg::OP_BYP_ENTER);
		chk(rd & 32'h04, 32'h04);
		op(nfcsm_pkg::OP_PROG);
		chk(rd & 32'h24, 32'h24);
		prog(nfcsm_pkg::OP_BYP_PROG, 21'h5, 16'h00AB);
		rdat(21'h5);
		chk(rd, 32'h00AB);
		op(nfcsm_pkg::OP_BYP_EXIT);
		chk({31'h0, nfcsm_flash_model_i.byp}, 32'h0);
		chk(rd & 32'h04, 32'h0);
		op(nfcsm_pkg::OP_AUTOSEL);
		rdat(21'h0);
		chk(rd, 32'h00C3);
		rdat(21'h101);
		chk(rd, 32'h1234);
		rdat(21'h2);
		chk(rd, 32'h0);
		op(nfcsm_pkg::OP_RESET);
		rdat(21'h3);
		chk(rd, 32'h1200);
		supply_ok <= 1'b0;
		repeat (4) @(posedge mclk);
		wb(1'b1, nfcsm_pkg::REG_STATUS, 32'h30);
		prog(nfcsm_pkg::OP_PROG, 21'h3, 16'h0000);
		chk(rd & 32'h20, 32'h20);
		wb(1'b1, nfcsm_pkg::REG_CFG, 32'h3);
		@(posedge mclk);
		chk({30'h0, fbyte, frst}, 32'h0);
		close_out();
	end
endmodule : tb_top
